// ===== spf_pkg.sv
// constants and types for the self-program flash control block
package spf_pkg;
    // control/status register, on the plain register port
    localparam logic [7:0] SPF_CSR_ADDR = 8'h37;
    localparam logic [7:0] SPF_CSR_RST  = 8'h00;
    localparam int SPF_B_IRQ_EN  = 7;
    localparam int SPF_B_BUSY    = 6;
    localparam int SPF_B_RSV     = 5;
    localparam int SPF_B_RE_EN   = 4;
    localparam int SPF_B_LOCK    = 3;
    localparam int SPF_B_PG_WR   = 2;
    localparam int SPF_B_PG_ER   = 1;
    localparam int SPF_B_ARM     = 0;
    // accepted low five bits of a control write
    localparam logic [4:0] SPF_C_RE_EN = 5'h11;
    localparam logic [4:0] SPF_C_LOCK  = 5'h09;
    localparam logic [4:0] SPF_C_PG_WR = 5'h05;
    localparam logic [4:0] SPF_C_PG_ER = 5'h03;
    localparam logic [4:0] SPF_C_FILL  = 5'h01;
    // lock byte positions, one = unprogrammed
    localparam logic [7:0] SPF_LOCK_ERASED = 8'hff;
    localparam logic [7:0] SPF_LOCK_KEEP   = 8'hc0;
    localparam int SPF_L_MEM_LO  = 0;
    localparam int SPF_L_MEM_HI  = 1;
    localparam int SPF_L_APP_LO  = 2;
    localparam int SPF_L_APP_HI  = 3;
    localparam int SPF_L_BOOT_LO = 4;
    localparam int SPF_L_BOOT_HI = 5;
    // flash geometry
    localparam int SPF_PAGE_W     = 7;
    localparam int SPF_Z_PAGE_LSB = 6;
    localparam int SPF_NO_READ_WHILE_WRITE_SECTION_PAGE  = 96;
    localparam int SPF_BOOT_MIN_PG = 4;
    // timing at 40 MHz
    localparam int SPF_CLK_NS  = 25;
    localparam logic [2:0] SPF_WIN_CYC = 3'h4;
    localparam logic [1:0] SPF_LDS_CYC = 2'h3;
    localparam int SPF_OP_TIME_NS = 4000000;
    localparam int SPF_OP_CYCLES  = SPF_OP_TIME_NS / SPF_CLK_NS;
    typedef enum logic [1:0]
    {
        SPF_IDLE  = 2'b00,
        SPF_ARMED = 2'b01,
        SPF_BUSY  = 2'b11
    } spf_state_e;
endpackage : spf_pkg

// ===== spf_ctrl.sv
// self-program flash sequencer with lock bits
//
// Behaviour
// - ready irq: enable and global flag, arm clear
// - rww erase/write sets busy, blocks rww
// - busy clears on re-enable or buffer fill
// - re-enable store within four cycles, not busy
// - re-enable during fill discards buffer data
// - lock set store programs locks from R0
// - lock-set bit clears on completion or timeout
// - load after lock set returns lock/fuse
// - page write from buffer, upper Z page
// - page erase of upper Z page
// - stall core during no-rww erase/write
// - arm alone fills buffer word with R1:R0
// - arm clears after store or timeout
// - other low five bit patterns ignored
// - locks only erased by chip erase (here RST_B also reloads them erased)
// - no boot variant: store needs fuse zero
// - memory lock 10 blocks ext programming
// - memory lock 00 also blocks verification
// - application lock pair decode
// - boot lock pair decode
// - suppress irqs across read-protected sections
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
module spf_ctrl
    import spf_pkg::*;
#(
    parameter int unsigned OP_CYCLES  = SPF_OP_CYCLES,
    parameter bit          HAS_BOOT   = 1'b1,
    parameter int          PAGE_W     = SPF_PAGE_W,
    parameter int          Z_PAGE_LSB = SPF_Z_PAGE_LSB
)
(
    // clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                RST_B,
    // register port
    input  wire logic [7:0]          REG_ADDR,
    input  wire logic [7:0]          REG_WDATA,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    output logic      [7:0]          REG_RDATA,
    // core status
    input  wire logic                GLOBAL_IRQ_EN,
    input  wire logic                CORE_IN_BOOT,
    input  wire logic                VEC_IN_BOOT,
    output logic                     STORE_READY_IRQ,
    output logic                     IRQ_SUPPRESS,
    output logic                     CPU_STALL,
    // program store instruction
    input  wire logic                STORE_REQ,
    input  wire logic [15:0]         STORE_Z,
    input  wire logic [7:0]          STORE_R0,
    input  wire logic [7:0]          STORE_R1,
    // program load instruction
    input  wire logic                LOAD_REQ,
    input  wire logic [15:0]         LOAD_Z,
    output logic                     LOAD_DENY,
    output logic                     LOAD_SPECIAL,
    output logic      [7:0]          LOAD_DATA,
    // fuses and chip erase
    input  wire logic                SELFPRG_FUSE,
    input  wire logic [1:0]          BOOT_SIZE,
    input  wire logic [7:0]          FUSE_LOW,
    input  wire logic                CHIP_ERASE,
    // flash array side
    output logic                     BUF_WR,
    output logic [Z_PAGE_LSB-2:0]    BUF_WORD,
    output logic [15:0]              BUF_DATA,
    output logic                     BUF_DISCARD,
    output logic                     PAGE_ERASE_GO,
    output logic                     PAGE_WRITE_GO,
    output logic [PAGE_W-1:0]        FLASH_PAGE,
    output logic                     RWW_BLOCK,
    // external programming protection
    output logic                     EXT_PROG_BLOCK,
    output logic                     EXT_VERIFY_BLOCK,
    output logic                     FUSE_LOCKED,
    output logic                     BOOT_LOCK_LOCKED
);

////////////////////////////////////////////////////////////////////////
    spf_state_e                 st_r;
    logic                       irq_en_r;
    logic                       busy_r;
    logic [3:0]                 cmd_r;
    logic [2:0]                 win_r;
    logic [1:0]                 lds_r;
    logic [7:0]                 lock_r;
    logic                       fill_act_r;
    logic                       tgt_rww_r;
    logic [31:0]                op_cnt_r;
    logic                       csr_wr;
    logic                       cmd_ok;
    logic                       take;
    logic [PAGE_W-1:0]          st_page;
    logic [PAGE_W-1:0]          ld_page;
    logic                       st_boot;
    logic                       wr_allow;
    logic                       ld_block;

    // true when the page sits in the boot loader section
    function automatic logic spf_is_boot
    (
        input logic [PAGE_W-1:0] pg,
        input logic [1:0]        bsz
    );
        logic [PAGE_W-1:0] n;
        n = PAGE_W'(SPF_BOOT_MIN_PG) << (~bsz);
        return HAS_BOOT && (pg >= PAGE_W'(-n));
    endfunction : spf_is_boot

////////////////////////////////////////////////////////////////////////
    assign csr_wr  = REG_WR && (REG_ADDR == SPF_CSR_ADDR);
    assign cmd_ok  = (REG_WDATA[4:0] == SPF_C_RE_EN) ||
                     (REG_WDATA[4:0] == SPF_C_LOCK)  ||
                     (REG_WDATA[4:0] == SPF_C_PG_WR) ||
                     (REG_WDATA[4:0] == SPF_C_PG_ER) ||
                     (REG_WDATA[4:0] == SPF_C_FILL);
    assign take    = (st_r == SPF_ARMED) && STORE_REQ;
    assign st_page = STORE_Z[Z_PAGE_LSB +: PAGE_W];
    assign ld_page = LOAD_Z[Z_PAGE_LSB +: PAGE_W];
    assign st_boot = spf_is_boot(st_page, BOOT_SIZE);

    // store permission by section lock and self-program fuse
    always_comb
    begin
        if (!HAS_BOOT)
            wr_allow = !SELFPRG_FUSE;
        else if (st_boot)
            wr_allow = lock_r[SPF_L_BOOT_LO];
        else
            wr_allow = lock_r[SPF_L_APP_LO];
    end

    // cross-section load protection
    always_comb
    begin
        ld_block = 1'b0;
        if (CORE_IN_BOOT && !spf_is_boot(ld_page, BOOT_SIZE))
            ld_block = !lock_r[SPF_L_APP_HI];
        if (!CORE_IN_BOOT && spf_is_boot(ld_page, BOOT_SIZE))
            ld_block = !lock_r[SPF_L_BOOT_HI];
    end

////////////////////////////////////////////////////////////////////////
    // sequencer: a busy erase/write refuses every new command
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_r     <= SPF_IDLE;
            cmd_r    <= 4'h0;
            win_r    <= 3'h0;
            op_cnt_r <= 32'h0;
        end
        else
        begin
            case (st_r)
                SPF_IDLE, SPF_ARMED:
                begin
                    if (take && (cmd_r[1:0] != 2'b00) && wr_allow)
                    begin
                        st_r     <= SPF_BUSY;
                        op_cnt_r <= 32'(OP_CYCLES - 1);
                    end
                    else if (take)
                    begin
                        st_r  <= SPF_IDLE;
                        cmd_r <= 4'h0;
                    end
                    else if (csr_wr && cmd_ok)
                    begin
                        st_r  <= SPF_ARMED;
                        cmd_r <= REG_WDATA[4:1];
                        win_r <= SPF_WIN_CYC;
                    end
                    else if (st_r == SPF_ARMED && win_r == 3'h1)
                    begin
                        st_r  <= SPF_IDLE;
                        cmd_r <= 4'h0;
                    end
                    else if (st_r == SPF_ARMED)
                        win_r <= win_r - 3'h1;
                end
                SPF_BUSY:
                begin
                    if (op_cnt_r == 32'h0)
                    begin
                        st_r  <= SPF_IDLE;
                        cmd_r <= 4'h0;
                    end
                    else
                        op_cnt_r <= op_cnt_r - 32'h1;
                end
                default:
                    st_r <= SPF_IDLE;
            endcase
        end
    end

    // interrupt enable is plain storage
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            irq_en_r <= SPF_CSR_RST[SPF_B_IRQ_EN];
        else if (csr_wr)
            irq_en_r <= REG_WDATA[SPF_B_IRQ_EN];
    end

    // section busy: a new rww operation wins over any clear
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            busy_r    <= SPF_CSR_RST[SPF_B_BUSY];
            tgt_rww_r <= 1'b0;
        end
        else if (take && cmd_r[1:0] != 2'b00 && wr_allow)
        begin
            tgt_rww_r <= (st_page < PAGE_W'(SPF_NO_READ_WHILE_WRITE_SECTION_PAGE));
            if (st_page < PAGE_W'(SPF_NO_READ_WHILE_WRITE_SECTION_PAGE))
                busy_r <= 1'b1;
        end
        else if (take && cmd_r == 4'h0)
            busy_r <= 1'b0;
        else if (take && cmd_r[3])
            busy_r <= 1'b0;
    end

    // buffer fill, discard and erase/write strobes
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            BUF_WR        <= 1'b0;
            BUF_WORD      <= '0;
            BUF_DATA      <= 16'h0;
            BUF_DISCARD   <= 1'b0;
            PAGE_ERASE_GO <= 1'b0;
            PAGE_WRITE_GO <= 1'b0;
            FLASH_PAGE    <= '0;
            fill_act_r    <= 1'b0;
        end
        else
        begin
            BUF_WR        <= take && cmd_r == 4'h0;
            PAGE_ERASE_GO <= take && cmd_r[0] && wr_allow;
            PAGE_WRITE_GO <= take && cmd_r[1] && wr_allow;
            BUF_DISCARD   <= 1'b0;
            if (take && cmd_r == 4'h0)
            begin
                BUF_WORD   <= STORE_Z[Z_PAGE_LSB-1:1];
                BUF_DATA   <= {STORE_R1, STORE_R0};
                fill_act_r <= 1'b1;
            end
            if (take && cmd_r[1:0] != 2'b00)
            begin
                FLASH_PAGE <= st_page;
                fill_act_r <= 1'b0;
            end
            if (csr_wr && REG_WDATA[SPF_B_RE_EN] && fill_act_r)
            begin
                BUF_DISCARD <= 1'b1;
                fill_act_r  <= 1'b0;
            end
        end
    end

    // lock byte: stores may only program bits to zero
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            lock_r <= SPF_LOCK_ERASED;
        else if (CHIP_ERASE)
            lock_r <= SPF_LOCK_ERASED;
        else if (take && cmd_r[2])
            lock_r <= lock_r & (STORE_R0 | SPF_LOCK_KEEP);
    end

    // short window in which loads read the lock or fuse byte
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            lds_r <= 2'h0;
        else if (csr_wr && REG_WDATA[4:0] == SPF_C_LOCK && st_r != SPF_BUSY)
            lds_r <= SPF_LDS_CYC;
        else if (lds_r != 2'h0)
            lds_r <= lds_r - 2'h1;
    end

    // load answers, one cycle after the request
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            LOAD_DENY    <= 1'b0;
            LOAD_SPECIAL <= 1'b0;
            LOAD_DATA    <= 8'h0;
        end
        else
        begin
            LOAD_SPECIAL <= LOAD_REQ && lds_r != 2'h0;
            LOAD_DENY    <= LOAD_REQ && lds_r == 2'h0 &&
                            (ld_block || (busy_r &&
                             ld_page < PAGE_W'(SPF_NO_READ_WHILE_WRITE_SECTION_PAGE)));
            if (LOAD_REQ && lds_r != 2'h0)
                LOAD_DATA <= LOAD_Z[0] ? FUSE_LOW : lock_r;
        end
    end

    // register read, reserved bit forced low
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            REG_RDATA <= 8'h0;
        else if (REG_RD && REG_ADDR == SPF_CSR_ADDR)
            REG_RDATA <= {irq_en_r, busy_r, 1'b0, cmd_r,
                          st_r != SPF_IDLE};
        else
            REG_RDATA <= 8'h0;
    end

////////////////////////////////////////////////////////////////////////
    // status to the core and external programming
    assign STORE_READY_IRQ = irq_en_r && GLOBAL_IRQ_EN &&
                             st_r == SPF_IDLE;
    assign IRQ_SUPPRESS    = (VEC_IN_BOOT && !CORE_IN_BOOT &&
                              !lock_r[SPF_L_APP_HI]) ||
                             (!VEC_IN_BOOT && CORE_IN_BOOT &&
                              !lock_r[SPF_L_BOOT_HI]);
    assign CPU_STALL       = st_r == SPF_BUSY && !tgt_rww_r;
    assign RWW_BLOCK       = busy_r;
    assign EXT_PROG_BLOCK  = !lock_r[SPF_L_MEM_LO];
    assign FUSE_LOCKED     = !lock_r[SPF_L_MEM_LO];
    assign EXT_VERIFY_BLOCK = !lock_r[SPF_L_MEM_LO] &&
                              !lock_r[SPF_L_MEM_HI];
    assign BOOT_LOCK_LOCKED = EXT_VERIFY_BLOCK;

////////////////////////////////////////////////////////////////////////
    a_win_expiry: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        st_r == SPF_ARMED && win_r == 3'h1 && !STORE_REQ && !csr_wr
        |=> st_r == SPF_IDLE && cmd_r == 4'h0)
        else $error("arm window did not expire");
    a_arm_window: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        csr_wr && cmd_ok && st_r == SPF_IDLE && !STORE_REQ
        ##1 (!STORE_REQ && !csr_wr) [*4] |=> st_r == SPF_IDLE)
        else $error("arm bit outlived four cycles");
    a_bad_cmd: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        csr_wr && !cmd_ok && st_r == SPF_IDLE |=> st_r == SPF_IDLE)
        else $error("illegal command armed");
    a_rww_busy: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        PAGE_ERASE_GO && tgt_rww_r |-> RWW_BLOCK)
        else $error("rww busy not set");
    a_fill_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        BUF_WR |-> !RWW_BLOCK)
        else $error("fill left rww busy");
    a_abort_fill: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        csr_wr && REG_WDATA[SPF_B_RE_EN] && fill_act_r
        |=> BUF_DISCARD ##1 !BUF_DISCARD)
        else $error("fill not discarded");
    a_rsv_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        REG_RD |=> !REG_RDATA[SPF_B_RSV])
        else $error("reserved bit read as one");
    a_lock_prog: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !$past(CHIP_ERASE) |-> (lock_r & ~$past(lock_r)) == 8'h0)
        else $error("lock bit returned to one");
    a_stall_busy: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        $rose(st_r == SPF_BUSY) && !tgt_rww_r |-> CPU_STALL [*2])
        else $error("no stall for no-rww operation");
    a_lock_read: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        LOAD_REQ && lds_r != 2'h0 && !LOAD_Z[0]
        |=> LOAD_SPECIAL && LOAD_DATA == $past(lock_r))
        else $error("lock byte not returned");

endmodule : spf_ctrl

// ===== spf_core_model.sv
// core model issuing program store and program load instructions
`timescale 1ns/10ps
module spf_core_model
(
    // clock and stall
    input  wire logic        clk,
    input  wire logic        stall,
    // store instruction
    output logic             store_req,
    output logic [15:0]      store_z,
    output logic [7:0]       store_r0,
    output logic [7:0]       store_r1,
    // load instruction
    output logic             load_req,
    output logic [15:0]      load_z
);
    initial
    begin
        store_req = 1'b0;
        load_req  = 1'b0;
        store_z   = 16'h0000;
        store_r0  = 8'h00;
        store_r1  = 8'h00;
        load_z    = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // released operands flip so a stale value can never pass for a live one
    task automatic store(input logic [15:0] z, input logic [7:0] r0,
                         input logic [7:0] r1);
        while (stall === 1'b1)
            @(posedge clk);
        store_req <= 1'b1;
        store_z   <= z;
        store_r0  <= r0;
        store_r1  <= r1;
        @(posedge clk);
        store_req <= 1'b0;
        store_z   <= ~z;
        store_r0  <= ~r0;
        store_r1  <= ~r1;
    endtask : store
    task automatic load(input logic [15:0] z);
        load_req <= 1'b1;
        load_z   <= z;
        @(posedge clk);
        load_req <= 1'b0;
        load_z   <= ~z;
    endtask : load
endmodule : spf_core_model

// ===== spf_ctrl_tb.sv
// self-checking bench for the self-program flash control block
`timescale 1ns/10ps
module spf_ctrl_tb;
    import spf_pkg::*;
    localparam int OPC = 20;
    logic        REF_CLK = 1'b0, RST_B = 1'b0;
    logic [7:0]  REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
    logic        REG_WR = 1'b0, REG_RD = 1'b0, GLOBAL_IRQ_EN = 1'b0;
    logic        CORE_IN_BOOT = 1'b0, VEC_IN_BOOT = 1'b0;
    logic        SELFPRG_FUSE = 1'b0, CHIP_ERASE = 1'b0;
    logic [1:0]  BOOT_SIZE = 2'h3;
    logic [7:0]  FUSE_LOW = 8'h62, STORE_R0, STORE_R1, LOAD_DATA;
    logic [15:0] STORE_Z, LOAD_Z, BUF_DATA;
    logic        STORE_REQ, LOAD_REQ, LOAD_DENY, LOAD_SPECIAL;
    logic        STORE_READY_IRQ, IRQ_SUPPRESS, CPU_STALL, BUF_WR;
    logic [4:0]  BUF_WORD;
    logic        BUF_DISCARD, PAGE_ERASE_GO, PAGE_WRITE_GO, RWW_BLOCK;
    logic [6:0]  FLASH_PAGE, pg;
    logic        EXT_PROG_BLOCK, EXT_VERIFY_BLOCK, FUSE_LOCKED;
    logic        BOOT_LOCK_LOCKED;
    logic [15:0] w_data;
    logic [4:0]  w_word;
    logic [7:0]  bad [6] = '{8'h07, 8'h0f, 8'h1f, 8'h02, 8'h10, 8'h08};
    int          n_fail = 0, num_checks = 0;
    int          n_wr, n_er, n_pw, n_ds, n_st;

    spf_ctrl #(.OP_CYCLES(OPC)) u_dut (
        .REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
        .CORE_IN_BOOT(CORE_IN_BOOT), .VEC_IN_BOOT(VEC_IN_BOOT),
        .STORE_READY_IRQ(STORE_READY_IRQ), .IRQ_SUPPRESS(IRQ_SUPPRESS),
        .CPU_STALL(CPU_STALL), .STORE_REQ(STORE_REQ), .STORE_Z(STORE_Z),
        .STORE_R0(STORE_R0), .STORE_R1(STORE_R1), .LOAD_REQ(LOAD_REQ),
        .LOAD_Z(LOAD_Z), .LOAD_DENY(LOAD_DENY),
        .LOAD_SPECIAL(LOAD_SPECIAL), .LOAD_DATA(LOAD_DATA),
        .SELFPRG_FUSE(SELFPRG_FUSE), .BOOT_SIZE(BOOT_SIZE),
        .FUSE_LOW(FUSE_LOW), .CHIP_ERASE(CHIP_ERASE), .BUF_WR(BUF_WR),
        .BUF_WORD(BUF_WORD), .BUF_DATA(BUF_DATA),
        .BUF_DISCARD(BUF_DISCARD), .PAGE_ERASE_GO(PAGE_ERASE_GO),
        .PAGE_WRITE_GO(PAGE_WRITE_GO), .FLASH_PAGE(FLASH_PAGE),
        .RWW_BLOCK(RWW_BLOCK), .EXT_PROG_BLOCK(EXT_PROG_BLOCK),
        .EXT_VERIFY_BLOCK(EXT_VERIFY_BLOCK), .FUSE_LOCKED(FUSE_LOCKED),
        .BOOT_LOCK_LOCKED(BOOT_LOCK_LOCKED));
    spf_core_model u_core (.clk(REF_CLK), .stall(CPU_STALL),
        .store_req(STORE_REQ), .store_z(STORE_Z), .store_r0(STORE_R0),
        .store_r1(STORE_R1), .load_req(LOAD_REQ), .load_z(LOAD_Z));

    initial
    begin
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    // pulse tallies, so a one-cycle strobe is never missed
    always @(posedge REF_CLK)
    begin
        if (BUF_WR === 1'b1) n_wr++;
        if (BUF_WR === 1'b1) w_data = BUF_DATA;
        if (BUF_WR === 1'b1) w_word = BUF_WORD;
        if (PAGE_ERASE_GO === 1'b1) n_er++;
        if (PAGE_WRITE_GO === 1'b1) n_pw++;
        if ((PAGE_ERASE_GO | PAGE_WRITE_GO) === 1'b1) pg = FLASH_PAGE;
        if (BUF_DISCARD === 1'b1) n_ds++;
        if (CPU_STALL === 1'b1) n_st++;
    end
    task automatic clr();
        {n_wr, n_er, n_pw, n_ds, n_st} = '0;
    endtask : clr
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] d);
        REG_ADDR  <= SPF_CSR_ADDR;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, e);
    endtask : rd
    // program the lock byte from R0, and Z carry junk
    task automatic lk(input logic [7:0] r0);
        wr(8'h09);
        u_core.store(16'hffff, r0, 8'h5a);
        repeat (3) @(posedge REF_CLK);
        rd(SPF_CSR_ADDR, 8'h00);
    endtask : lk
    task automatic ldl(input logic [15:0] z, input int gap,
                       input logic sp, input logic [7:0] e);
        wr(8'h09);
        repeat (gap) @(posedge REF_CLK);
        u_core.load(z);
        #1 chk(LOAD_SPECIAL, sp);
        if (sp) chk(LOAD_DATA, e);
        repeat (5) @(posedge REF_CLK);
    endtask : ldl
    task automatic ers(input logic [15:0] z);
        clr();
        wr(8'h03);
        u_core.store(z, 8'h00, 8'h00);
        repeat (OPC + 4) @(posedge REF_CLK);
    endtask : ers
    task automatic cerase();
        CHIP_ERASE <= 1'b1;
        @(posedge REF_CLK);
        CHIP_ERASE <= 1'b0;
        @(posedge REF_CLK);
    endtask : cerase
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #(25 * 5000);
        n_fail++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge REF_CLK);
        RST_B <= 1'b1;
        @(posedge REF_CLK);
        rd(SPF_CSR_ADDR, SPF_CSR_RST);
        rd(8'h38, 8'h00);
        wr(8'h01);
        rd(SPF_CSR_ADDR, 8'h01);
        repeat (2) @(posedge REF_CLK);
        rd(SPF_CSR_ADDR, 8'h01);
        rd(SPF_CSR_ADDR, 8'h00);
        foreach (bad[i])
        begin
            wr(bad[i]);
            rd(SPF_CSR_ADDR, 8'h00);
        end
        $display("test window and codes done");
        GLOBAL_IRQ_EN <= 1'b1;
        wr(8'h80);
        #1 chk(STORE_READY_IRQ, 1'b1);
        wr(8'h81);
        #1 chk(STORE_READY_IRQ, 1'b0);
        repeat (5) @(posedge REF_CLK);
        #1 chk(STORE_READY_IRQ, 1'b1);
        GLOBAL_IRQ_EN <= 1'b0;
        #1 chk(STORE_READY_IRQ, 1'b0);
        wr(8'h00);
        // let the strobe fall before the next write raises it
        @(posedge REF_CLK);
        $display("test ready irq done");
        clr();
        wr(8'h03);
        u_core.store(16'h0140, 8'h00, 8'h00);
        rd(SPF_CSR_ADDR, 8'h43);
        u_core.load(16'h0140);
        #1 chk(LOAD_DENY, 1'b1);
        wr(8'h11);
        repeat (OPC) @(posedge REF_CLK);
        #1 chk(n_er, 1);
        chk(pg, 7'h05);
        chk(RWW_BLOCK, 1'b1);
        rd(SPF_CSR_ADDR, 8'h40);
        // software waits for arm to clear before re-enabling
        wr(8'h11);
        u_core.store(16'h0000, 8'h00, 8'h00);
        @(posedge REF_CLK);
        #1 chk(RWW_BLOCK, 1'b0);
        ers(16'h0140);
        wr(8'h01);
        u_core.store(16'h0043, 8'hcd, 8'hab);
        @(posedge REF_CLK);
        #1 chk(w_data, 16'habcd);
        chk(w_word, 5'h01);
        chk(n_wr, 1);
        chk(RWW_BLOCK, 1'b0);
        $display("test erase and fill done");
        clr();
        wr(8'h05);
        u_core.store(16'h1900, 8'h11, 8'h22);
        repeat (OPC + 4) @(posedge REF_CLK);
        #1 chk(n_pw, 1);
        chk(pg, 7'h64);
        chk(n_st >= OPC && n_st <= OPC + 1, 1'b1);
        chk(RWW_BLOCK, 1'b0);
        rd(SPF_CSR_ADDR, 8'h00);
        // a word must sit in the buffer before a re-enable can drop it
        clr();
        wr(8'h01);
        u_core.store(16'h0002, 8'h34, 8'h12);
        wr(8'h11);
        repeat (2) @(posedge REF_CLK);
        #1 chk(n_ds, 1);
        chk(n_wr, 1);
        repeat (5) @(posedge REF_CLK);
        $display("test page write and abort done");
        ldl(16'h0000, 0, 1'b1, 8'hff);
        ldl(16'h0001, 2, 1'b1, 8'h62);
        ldl(16'h0000, 3, 1'b0, 8'h00);
        lk(8'hfb);
        ldl(16'h0000, 0, 1'b1, 8'hfb);
        ers(16'h0140);
        #1 chk(n_er, 0);
        rd(SPF_CSR_ADDR, 8'h00);
        cerase();
        ldl(16'h0000, 0, 1'b1, 8'hff);
        lk(8'hf3);
        CORE_IN_BOOT <= 1'b1;
        u_core.load(16'h0140);
        #1 chk(LOAD_DENY, 1'b1);
        VEC_IN_BOOT  <= 1'b1;
        CORE_IN_BOOT <= 1'b0;
        #1 chk(IRQ_SUPPRESS, 1'b1);
        CORE_IN_BOOT <= 1'b1;
        #1 chk(IRQ_SUPPRESS, 1'b0);
        cerase();
        lk(8'hef);
        ers(16'h1fc0);
        #1 chk(n_er, 0);
        cerase();
        lk(8'hcf);
        CORE_IN_BOOT <= 1'b0;
        u_core.load(16'h1fc0);
        #1 chk(LOAD_DENY, 1'b1);
        cerase();
        lk(8'hfe);
        chk(EXT_PROG_BLOCK, 1'b1);
        chk(FUSE_LOCKED, 1'b1);
        chk(EXT_VERIFY_BLOCK, 1'b0);
        lk(8'hfc);
        chk(EXT_VERIFY_BLOCK, 1'b1);
        chk(BOOT_LOCK_LOCKED, 1'b1);
        cerase();
        #1 chk(EXT_PROG_BLOCK, 1'b0);
        $display("test lock bits done");
        report_and_stop();
    end
endmodule : spf_ctrl_tb
